// [logic/timer16_defines.svh]
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_COUNT_HIGH      8'he4
`define IDX_COUNT_LOW       8'he5
`define IDX_REF_HIGH        8'he6
`define IDX_REF_LOW         8'he7
`define IDX_CONTROL         8'he8
`define ADDR_COUNT_HIGH     12'h390
`define ADDR_COUNT_LOW      12'h394
`define ADDR_REF_HIGH       12'h398
`define ADDR_REF_LOW        12'h39c
`define ADDR_CONTROL        12'h3a0
`define ADDR_WIDTH          12

// Control register fields
`define CTL_PEND_BIT        0
`define CTL_MC_EN_BIT       1
`define CTL_OVF_EN_BIT      2
`define CTL_CLEAR_BIT       3
`define CTL_EDGE_LSB        4
`define CTL_EDGE_MSB        5
`define CTL_CLK_LSB         6
`define CTL_CLK_MSB         7
`define CTL_RESET           8'h00

// Interrupt vectors
`define VEC_OVERFLOW        8'hf0
`define VEC_MATCH_CAPTURE   8'hf2

`define COUNT_MAX           16'hffff
`define COUNT_ZERO          16'h0000
`define REF_RESET           16'h0000

`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// [logic/timer16_match_capture.sv]
// Overview of operation
// - Sixteen-bit up counter with reference comparator
// - Tick from core clock divided 4, 8, 16
// - Tick may come from companion flip-flop output
// - Overflow request at FFFF when enabled
// - Count wraps to zero after overflow, continues
// - Writing one to bit 3 clears count
// - Match mode: equal reference raises request, restarts
// - Capture mode: selected pin edge raises request
// - Bits 5:4 select rising, falling or both
// - Bit 0 reads pending match/capture status
// - Pending bit read status, write only clears
// - Overflow vector F0, match/capture vector F2
// - Overflow request outranks match/capture request
// - Separate interrupt enables and mode selection bits
// - Control clears to zero on reset
// - Count two read-only bytes, reference two RW
//
// The AXI4-Lite slave port is this design's own decision.
`include "timer16_defines.svh"
`default_nettype none
module timer16_match_capture (
    input  wire logic                   core_clk,       // 250 MHz clock
    input  wire logic                   rst_n,          // Async reset, active low
    input  wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,   // Write address
    input  wire logic                   s_axi_awvalid,  // Write address valid
    output logic                        s_axi_awready,  // Write address ready
    input  wire logic [31:0]            s_axi_wdata,    // Write data
    input  wire logic [3:0]             s_axi_wstrb,    // Write strobes
    input  wire logic                   s_axi_wvalid,   // Write data valid
    output logic                        s_axi_wready,   // Write data ready
    output logic [1:0]                  s_axi_bresp,    // Write response
    output logic                        s_axi_bvalid,   // Write response valid
    input  wire logic                   s_axi_bready,   // Write response ready
    input  wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,   // Read address
    input  wire logic                   s_axi_arvalid,  // Read address valid
    output logic                        s_axi_arready,  // Read address ready
    output logic [31:0]                 s_axi_rdata,    // Read data
    output logic [1:0]                  s_axi_rresp,    // Read response
    output logic                        s_axi_rvalid,   // Read data valid
    input  wire logic                   s_axi_rready,   // Read data ready
    input  wire logic                   captureInputPin, // Capture pin
    input  wire logic                   companionFlop,  // Companion counter flop output
    input  wire logic                   intAck,         // Controller acknowledge pulse
    output logic                        intReq,         // Timer interrupt level request
    output logic [7:0]                  intVector,      // Vector of highest request
    output logic                        overflowTick    // Pulse on each wrap
);
    import timer16_pkg::*;

    // Register state
    logic [7:0]  control;
    logic [15:0] count;
    logic [15:0] reference;
    logic        overflowPending;
    logic [3:0]  prescale;
    logic        companionPrev;
    logic        capSync1;
    logic        capSync2;
    logic        capPrev;
    logic [7:0]  next_control;
    logic [15:0] next_count;
    logic [15:0] next_reference;
    logic        next_overflowPending;
    logic [3:0]  next_prescale;
    logic        next_capSync1;
    logic        next_capSync2;
    logic        next_capPrev;
    logic        next_overflowTick;
    logic        next_companionPrev;
    logic [7:0]  next_intVector;

    // Bus state
    logic                   awHeld;
    logic                   wHeld;
    logic [`ADDR_WIDTH-1:0] awAddr;
    logic [7:0]             wByte;
    logic                   wLane;
    logic                   next_awHeld;
    logic                   next_wHeld;
    logic [`ADDR_WIDTH-1:0] next_awAddr;
    logic [7:0]             next_wByte;
    logic                   next_wLane;
    logic                   next_bvalid;
    logic [1:0]             next_bresp;
    logic                   next_rvalid;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;

    clk_sel_e   clkSel;
    edge_mode_e edgeMode;
    logic       tick;
    logic       doWrite;
    logic       wrControl;
    logic       riseSeen;
    logic       fallSeen;
    logic       captureHit;
    logic       matchHit;
    logic       wrapHit;
    logic       mcEvent;

    assign clkSel   = clk_sel_e'(control[`CTL_CLK_MSB:`CTL_CLK_LSB]);
    assign edgeMode = edge_mode_e'(control[`CTL_EDGE_MSB:`CTL_EDGE_LSB]);

    // Timer tick selection
    always_comb begin
        case (clkSel)
            CLK_DIV4:  tick = (prescale[1:0] == 2'h3);
            CLK_DIV8:  tick = (prescale[2:0] == 3'h7);
            CLK_DIV16: tick = (prescale == 4'hf);
            CLK_COMPANION: tick = companionFlop && !companionPrev;
            default:   tick = 1'b0;
        endcase
    end

    assign s_axi_awready = !awHeld;
    assign s_axi_wready  = !wHeld;
    assign doWrite   = awHeld && wHeld && !s_axi_bvalid;
    assign wrControl = doWrite && wLane && (awAddr == `ADDR_CONTROL);

    // Edge detection on synchronised sample
    assign riseSeen   = capSync2 && !capPrev;
    assign fallSeen   = !capSync2 && capPrev;
    always_comb begin
        case (edgeMode)
            EDGE_RISING:  captureHit = tick && riseSeen;
            EDGE_FALLING: captureHit = tick && fallSeen;
            EDGE_BOTH:    captureHit = tick && (riseSeen || fallSeen);
            default:      captureHit = 1'b0;
        endcase
    end
    assign matchHit = tick && (edgeMode == EDGE_NONE) && (count == reference);
    assign wrapHit  = tick && (count == `COUNT_MAX);
    assign mcEvent  = matchHit || captureHit;

    // Divider, companion edge and pin pipeline
    always_comb begin
        next_prescale      = prescale + 4'h1;
        next_companionPrev = companionFlop;
        next_capSync1      = capSync1;
        next_capSync2      = capSync2;
        next_capPrev       = capPrev;
        if (tick) begin
            next_capSync1 = captureInputPin;
            next_capSync2 = capSync1;
            next_capPrev  = capSync2;
        end
        // Realign divider so a cleared count starts a full period
        if (wrControl && wByte[`CTL_CLEAR_BIT]) begin
            next_prescale = 4'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale      <= 4'h0;
            companionPrev <= 1'b0;
            capSync1      <= 1'b0;
            capSync2      <= 1'b0;
            capPrev       <= 1'b0;
        end else begin
            prescale      <= next_prescale;
            companionPrev <= next_companionPrev;
            capSync1      <= next_capSync1;
            capSync2      <= next_capSync2;
            capPrev       <= next_capPrev;
        end
    end

    // Count, reference and control next state
    always_comb begin
        next_control   = control;
        next_count     = count;
        next_reference = reference;
        if (tick) begin
            if (wrapHit || matchHit) begin
                next_count = `COUNT_ZERO;
            end else begin
                next_count = count + 16'h0001;
            end
        end
        if (doWrite && wLane) begin
            case (awAddr)
                `ADDR_REF_HIGH: next_reference[15:8] = wByte;
                `ADDR_REF_LOW:  next_reference[7:0]  = wByte;
                default: ;
            endcase
        end
        if (wrControl) begin
            next_control[7:1] = wByte[7:1];
            next_control[`CTL_CLEAR_BIT] = 1'b0;
            // Zero clears, one leaves pending unchanged
            next_control[`CTL_PEND_BIT] = control[`CTL_PEND_BIT]
                                          && wByte[`CTL_PEND_BIT];
            if (wByte[`CTL_CLEAR_BIT]) begin
                next_count = `COUNT_ZERO;
            end
        end
        // Capture outranks a bus write to the reference
        if (captureHit) begin
            next_reference = count;
        end
        // Hardware set wins over a software clear
        if (mcEvent && control[`CTL_MC_EN_BIT]) begin
            next_control[`CTL_PEND_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control   <= `CTL_RESET;
            count     <= `COUNT_ZERO;
            reference <= `REF_RESET;
        end else begin
            control   <= next_control;
            count     <= next_count;
            reference <= next_reference;
        end
    end

    // Overflow request, wrap pulse and vector
    always_comb begin
        next_overflowPending = overflowPending;
        next_overflowTick    = wrapHit;
        if (intAck && overflowPending) begin
            next_overflowPending = 1'b0;
        end
        // A fresh wrap wins over the acknowledge
        if (wrapHit && control[`CTL_OVF_EN_BIT]) begin
            next_overflowPending = 1'b1;
        end
        // Vector registered with the pending state it reports
        next_intVector = `VEC_MATCH_CAPTURE;
        if (next_overflowPending) begin
            next_intVector = `VEC_OVERFLOW;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflowPending <= 1'b0;
            overflowTick    <= 1'b0;
            intVector       <= `VEC_MATCH_CAPTURE;
        end else begin
            overflowPending <= next_overflowPending;
            overflowTick    <= next_overflowTick;
            intVector       <= next_intVector;
        end
    end

    assign intReq = overflowPending || control[`CTL_PEND_BIT];

    // Bus next state
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld  = wHeld;
        next_awAddr = awAddr;
        next_wByte  = wByte;
        next_wLane  = wLane;
        next_bvalid = s_axi_bvalid;
        next_bresp  = s_axi_bresp;
        if (s_axi_awvalid && !awHeld) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld) begin
            next_wHeld = 1'b1;
            next_wByte = s_axi_wdata[7:0];
            next_wLane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            case (awAddr)
                `ADDR_COUNT_HIGH, `ADDR_COUNT_LOW, `ADDR_REF_HIGH,
                `ADDR_REF_LOW, `ADDR_CONTROL: next_bresp = `RESP_OKAY;
                default: next_bresp = `RESP_SLVERR;
            endcase
        end
    end

    // Read channel next state
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            case (s_axi_araddr)
                `ADDR_COUNT_HIGH: next_rdata = {24'h000000, count[15:8]};
                `ADDR_COUNT_LOW:  next_rdata = {24'h000000, count[7:0]};
                `ADDR_REF_HIGH:   next_rdata = {24'h000000, reference[15:8]};
                `ADDR_REF_LOW:    next_rdata = {24'h000000, reference[7:0]};
                `ADDR_CONTROL:    next_rdata = {24'h000000, control};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= '0;
            wByte        <= 8'h00;
            wLane        <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            awHeld       <= next_awHeld;
            wHeld        <= next_wHeld;
            awAddr       <= next_awAddr;
            wByte        <= next_wByte;
            wLane        <= next_wLane;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

endmodule
`default_nettype wire

// [logic/timer16_pkg.sv]
`default_nettype none
package timer16_pkg;

    typedef enum logic [1:0] {
        CLK_DIV4      = 2'b00,
        CLK_DIV8      = 2'b01,
        CLK_DIV16     = 2'b10,
        CLK_COMPANION = 2'b11
    } clk_sel_e;

    // Edge field doubles as mode select: none means interval mode
    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } edge_mode_e;

endpackage
`default_nettype wire

// [sim/testbench.sv]
`include "timer16_defines.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, rst_n = 0, intAck = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, captureInputPin = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, intReq, overflowTick, companionFlop = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  intVector;
    int          n_mismatch = 0, compares = 0;
    timer16_match_capture timer16_match_capture_inst (.core_clk, .rst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .captureInputPin, .companionFlop, .intAck, .intReq, .intVector,
        .overflowTick);
    initial forever #2 core_clk = ~core_clk;
    // Companion output rises every 8 cycles
    initial forever begin
        repeat (4) @(posedge core_clk);
        companionFlop <= ~companionFlop;
    end
    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aok, wok, bok;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bok = 0;
        while (!bok) begin
            @(negedge core_clk);
            aok = s_axi_awvalid && s_axi_awready;
            wok = s_axi_wvalid && s_axi_wready;
            bok = s_axi_bvalid;
            @(posedge core_clk);
            if (aok) s_axi_awvalid <= 1'b0;
            if (wok) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic aok, rok;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rok = 0;
        while (!rok) begin
            @(negedge core_clk);
            aok = s_axi_arvalid && s_axi_arready;
            rok = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (aok) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] re);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk(r, re);
    endtask
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && intReq !== 1'b1; i++) @(negedge core_clk);
    endtask
    task automatic t_reset();
        rdchk(`ADDR_CONTROL, 32'h00, `RESP_OKAY);
        rdchk(`ADDR_REF_HIGH, 32'h00, `RESP_OKAY);
        rdchk(`ADDR_REF_LOW, 32'h00, `RESP_OKAY);
        rdchk(`ADDR_COUNT_HIGH, 32'h00, `RESP_OKAY);
        rdchk(12'h000, 32'h00, `RESP_SLVERR);
        chk(intReq, 1'b0);
        chk(overflowTick, 1'b0);
    endtask
    task automatic t_hold();
        @(posedge core_clk);
        s_axi_araddr <= `ADDR_CONTROL;
        s_axi_arvalid <= 1'b1;
        @(negedge core_clk);
        while (!s_axi_arready) @(negedge core_clk);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        repeat (3) @(posedge core_clk);
        s_axi_rready <= 1'b1;
        @(negedge core_clk);
        while (!s_axi_rvalid) @(negedge core_clk);
        chk(s_axi_arready, 1'b0);
        chk(s_axi_rdata, 32'h00);
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_refs();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`ADDR_REF_HIGH, 8'h12);
        wr(`ADDR_REF_LOW, 8'h34);
        wr(`ADDR_COUNT_LOW, 8'haa);
        rdchk(`ADDR_REF_HIGH, 32'h12, `RESP_OKAY);
        rdchk(`ADDR_REF_LOW, 32'h34, `RESP_OKAY);
        rd(`ADDR_COUNT_LOW, d, r);
        chk(32'(d[7:0] !== 8'haa), 1);
    endtask
    task automatic t_clk();
        logic [31:0] d;
        logic [1:0]  r;
        int          lo;
        wr(`ADDR_REF_HIGH, 8'hff);
        wr(`ADDR_REF_LOW, 8'hff);
        for (int s = 0; s < 4; s++) begin
            lo = (s == 3) ? 20 : 160 >> (s + 2);
            wr(`ADDR_CONTROL, {2'(s), 6'h08});
            repeat (160) @(posedge core_clk);
            rd(`ADDR_COUNT_LOW, d, r);
            chk(32'(d[7:0] >= lo && d[7:0] <= lo + 3), 1);
        end
    endtask
    task automatic t_match();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`ADDR_REF_HIGH, 8'h00);
        wr(`ADDR_REF_LOW, 8'h10);
        wr(`ADDR_CONTROL, 8'h0a);
        wait_irq(300);
        chk(intReq, 1'b1);
        chk(intVector, `VEC_MATCH_CAPTURE);
        rdchk(`ADDR_CONTROL, 32'h03, `RESP_OKAY);
        rd(`ADDR_COUNT_LOW, d, r);
        chk(32'(d[7:0] < 8'h10), 1);
        wr(`ADDR_CONTROL, 8'h02);
        @(negedge core_clk);
        chk(intReq, 1'b0);
        wr(`ADDR_CONTROL, 8'h0b);
        rdchk(`ADDR_CONTROL, 32'h02, `RESP_OKAY);
        wr(`ADDR_CONTROL, 8'h08);
        repeat (300) @(negedge core_clk);
        chk(intReq, 1'b0);
    endtask
    task automatic t_capture();
        logic e;
        for (int i = 0; i < 6; i++) begin
            e = 6'b111001 >> i;
            wr(`ADDR_REF_HIGH, 8'hff);
            wr(`ADDR_CONTROL, 8'h0a | 8'((i / 2 + 1) << 4));
            repeat (20) @(posedge core_clk);
            captureInputPin <= ~i[0];
            wait_irq(120);
            chk(intReq, e);
            if (e) rdchk(`ADDR_REF_HIGH, 32'h00, `RESP_OKAY);
        end
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_hold();
        t_refs();
        t_clk();
        t_match();
        t_capture();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end
endmodule
bind timer16_match_capture timer16_properties timer16_properties_inst (.core_clk, .rst_n,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .intReq, .intVector, .overflowTick);
`default_nettype wire

// [sim/timer16_properties.sv]
`include "timer16_defines.svh"
`default_nettype none
module timer16_properties (
    input wire logic        core_clk,      // Clock
    input wire logic        rst_n,         // Reset
    input wire logic [11:0] s_axi_araddr,  // Read address
    input wire logic        s_axi_arvalid, // Read valid
    input wire logic        s_axi_arready, // Read ready
    input wire logic [31:0] s_axi_rdata,   // Read data
    input wire logic [1:0]  s_axi_rresp,   // Read response
    input wire logic        s_axi_rvalid,  // Data valid
    input wire logic        s_axi_rready,  // Data ready
    input wire logic        s_axi_awvalid, // Write address valid
    input wire logic        s_axi_awready, // Write address ready
    input wire logic        s_axi_wvalid,  // Write data valid
    input wire logic        s_axi_wready,  // Write data ready
    input wire logic        s_axi_bvalid,  // Response valid
    input wire logic        intReq,        // Request
    input wire logic [7:0]  intVector,     // Vector
    input wire logic        overflowTick   // Wrap pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_aw;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_vec;
        intVector == `VEC_OVERFLOW || intVector == `VEC_MATCH_CAPTURE;
    endproperty
    property p_prio;
        intVector == `VEC_OVERFLOW |-> intReq;
    endproperty
    property p_tick;
        overflowTick |=> !overflowTick;
    endproperty
    property p_rd_lat;
        s_ar |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    property p_clr_reads0;
        s_ar ##0 s_axi_araddr == `ADDR_CONTROL |=> s_axi_rdata[3] == 1'b0;
    endproperty
    property p_unmapped;
        s_ar ##0 s_axi_araddr == 12'h000 |=> s_axi_rresp == `RESP_SLVERR;
    endproperty
    property p_wr_lat;
        s_aw |-> ##2 s_axi_bvalid;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    a_prio: assert property (p_prio) else $error("overflow vector without request");
    a_tick: assert property (p_tick) else $error("wrap pulse too long");
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    a_clr_reads0: assert property (p_clr_reads0) else $error("clear bit reads one");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read okay");
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
endmodule
`default_nettype wire
